// file: rtl/iwd_consts.vh
/*
 Constants for the instruction word decoder: opcodes, field positions,
 register offsets, reset values and sequencer timing.
 Assumes it is included by bare name in every file that needs it.
*/
`ifndef IWD_CONSTS_VH
`define IWD_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define IWD_OSC_PER_CYCLE 4
`define IWD_Q_W           2
`define IWD_Q_LAST        2'h3

// ****************************************
// Widths and reset values
// ****************************************
`define IWD_PC_W          21
`define IWD_PC_RST        21'h000000
`define IWD_PC_STEP       21'h000002
`define IWD_FA_W          12
`define IWD_BANK_RST      4'h0
`define IWD_ACC_RST       8'h00
`define IWD_NOP_WORD      16'h0000

// ****************************************
// Opcode patterns
// ****************************************
`define IWD_OP_AND        6'h05
`define IWD_OP_BR_CARRY   8'he2
`define IWD_OP_GOTO       8'hef
`define IWD_OP_CALL       7'h76
`define IWD_OP_MOVE_FILE  4'hc
`define IWD_OP_BSET       4'h8
`define IWD_OP_BCLR       4'h9
`define IWD_OP_CONT       4'hf

// ****************************************
// Operand field positions
// ****************************************
`define IWD_D_BIT         9
`define IWD_A_BIT         8
`define IWD_ACC_BANK_TOP  7
`define IWD_ACC_LO_BANK   4'h0
`define IWD_ACC_HI_BANK   4'hf

// ****************************************
// Register offsets and status bits
// ****************************************
`define IWD_REG_CTRL      4'h0
`define IWD_REG_BANK      4'h1
`define IWD_REG_ACC       4'h2
`define IWD_REG_STAT      4'h3
`define IWD_REG_PCL       4'h4
`define IWD_REG_PCM       4'h5
`define IWD_REG_PCH       4'h6
`define IWD_REG_IRL       4'h7
`define IWD_REG_IRH       4'h8
`define IWD_ST_C          0
`define IWD_ST_Z          2
`define IWD_ST_N          4

`endif

// file: rtl/iwd_file_ram.v
/*
 Data file register memory: one write port, one read port, read data
 registered one clock after the read enable.
 Assumes a single clock and that the caller never reads and writes
 the same address in one clock when it cares about the result.
*/
`timescale 1ns/100ps

module iwd_file_ram #(
   parameter ADDR_W = 12,
   parameter DATA_W = 8
) (
   input  wire              i_clock,
   input  wire              i_rd_en,
   input  wire [ADDR_W-1:0] i_rd_addr,
   output reg  [DATA_W-1:0] o_rd_data,
   input  wire              i_wr_en,
   input  wire [ADDR_W-1:0] i_wr_addr,
   input  wire [DATA_W-1:0] i_wr_data
);

   reg [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];

   // ****************************************
   // Storage
   // ****************************************

   // Write port and registered read port.
   always @(posedge i_clock) begin
      if (i_wr_en) begin
         mem_r[i_wr_addr] <= i_wr_data;
      end
      if (i_rd_en) begin
         o_rd_data <= mem_r[i_rd_addr];
      end
   end

endmodule

// file: rtl/iwd_decoder.v
/*
 Instruction word decoder and sequencer for an 8-bit core. Fetches
 16-bit program words, decodes single and double word formats, runs
 each instruction cycle as four clock phases and performs the
 read-modify-write of data file registers.
 Assumes program memory on i_clock answers within one instruction
 cycle: i_pm_word is sampled in the last phase for o_pm_addr_r.
*/
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "iwd_consts.vh"

module iwd_decoder #(
   parameter FA_W = `IWD_FA_W
) (
   input  wire                 i_clock,
   input  wire                 i_nrst,
   input  wire [15:0]          i_pm_word,
   output reg  [`IWD_PC_W-1:0] o_pm_addr_r,
   output reg                  o_rmw_rd_r,
   output reg  [FA_W-1:0]      o_rmw_addr_r,
   output reg                  o_cycle_start_r,
   input  wire [3:0]           i_reg_addr,
   input  wire [7:0]           i_reg_wdata,
   input  wire                 i_reg_wr,
   input  wire                 i_reg_rd,
   output reg  [7:0]           o_reg_rdata_r
);

   // ****************************************
   // Declarations
   // ****************************************
   reg                  rst_meta_r;
   reg                  rst_n_r;
   reg [`IWD_Q_W-1:0]   q_r;
   reg [15:0]           ir_r;
   reg [15:0]           w2_r;
   reg                  second_r;
   reg                  flush_r;
   reg                  run_r;
   reg [3:0]            bank_selector_r;
   reg [7:0]            working_accumulator_r;
   reg                  flag_n_r;
   reg                  flag_z_r;
   reg                  flag_c_r;
   reg [7:0]            opnd_r;
   reg [7:0]            result_r;
   reg [7:0]            result_nxt;
   reg [FA_W-1:0]       file_addr;
   reg [7:0]            bit_mask;

   wire [7:0]           ram_rd_data;
   wire                 is_cont;
   wire                 is_and;
   wire                 is_branch_if_carry_set;
   wire                 is_goto;
   wire                 is_call;
   wire                 is_move_file;
   wire                 is_bset;
   wire                 is_bclr;
   wire                 is_dword;
   wire                 nop_cyc;
   wire                 exec_now;
   wire                 need_read;
   wire                 to_file;
   wire                 writes_file;
   wire                 writes_acc;
   wire                 jump_now;
   wire                 step_q;
   wire                 phase_end;
   wire [FA_W-1:0]      wr_addr;
   wire [`IWD_PC_W-1:0] br_target;
   wire [`IWD_PC_W-1:0] goto_target;
   wire                 sw_wr_acc;
   wire                 sw_wr_stat;

   // ****************************************
   // Reset release
   // ****************************************

   // Reset is applied at once and released through two flip-flops.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ****************************************
   // Decode
   // ****************************************

   // Opcode field compares on the 16-bit word held in the instruction register.
   assign is_cont  = (ir_r[15:12] == `IWD_OP_CONT);
   assign is_and   = (ir_r[15:10] == `IWD_OP_AND);
   assign is_branch_if_carry_set = (ir_r[15:8] == `IWD_OP_BR_CARRY);
   assign is_goto  = (ir_r[15:8] == `IWD_OP_GOTO);
   assign is_call  = (ir_r[15:9] == `IWD_OP_CALL);
   assign is_move_file = (ir_r[15:12] == `IWD_OP_MOVE_FILE);
   assign is_bset  = (ir_r[15:12] == `IWD_OP_BSET);
   assign is_bclr  = (ir_r[15:12] == `IWD_OP_BCLR);
   assign is_dword = is_goto | is_call | is_move_file;

   // A flushed slot or a lone continuation word does nothing.
   assign nop_cyc   = flush_r | (is_cont & ~second_r);
   // Double words act only once the second word is held.
   assign exec_now  = ~nop_cyc & (~is_dword | second_r);
   assign need_read = exec_now & (is_and | is_bset | is_bclr | is_move_file);
   assign to_file   = ir_r[`IWD_D_BIT];
   assign writes_file = need_read & (~is_and | to_file);
   assign writes_acc  = exec_now & is_and & ~to_file;
   assign jump_now  = exec_now
                    & ((is_branch_if_carry_set & flag_c_r) | is_goto | is_call);
   assign wr_addr   = is_move_file ? w2_r[FA_W-1:0] : file_addr;

   // Branch target: counter already points past this word.
   assign br_target = o_pm_addr_r
                    + {{(`IWD_PC_W-9){ir_r[7]}}, ir_r[7:0], 1'b0};
   assign goto_target = {w2_r[11:0], ir_r[7:0], 1'b0};

   // File address from the 12-bit field for a file move, else from access bit, bank selector and 8-bit file field.
   always @* begin
      if (is_move_file) begin
         file_addr = ir_r[FA_W-1:0];
      end else if (ir_r[`IWD_A_BIT]) begin
         file_addr = {bank_selector_r, ir_r[7:0]};
      end else if (ir_r[`IWD_ACC_BANK_TOP]) begin
         file_addr = {`IWD_ACC_HI_BANK, ir_r[7:0]};
      end else begin
         file_addr = {`IWD_ACC_LO_BANK, ir_r[7:0]};
      end
   end

   // Bit mask from the three-bit bit field.
   always @* begin
      bit_mask = 8'h01 << ir_r[11:9];
   end

   // Data path result for the process phase.
   always @* begin
      if (is_and) begin
         result_nxt = working_accumulator_r & opnd_r;
      end else if (is_bset) begin
         result_nxt = opnd_r | bit_mask;
      end else if (is_bclr) begin
         result_nxt = opnd_r & ~bit_mask;
      end else begin
         result_nxt = opnd_r;
      end
   end

   // ****************************************
   // Data file
   // ****************************************

   // Read in the first phase, store in the last one.
   iwd_file_ram #(
      .ADDR_W (FA_W),
      .DATA_W (8)
   ) u_file_ram (
      .i_clock   (i_clock),
      .i_rd_en   (need_read & (q_r == 2'h0)),
      .i_rd_addr (file_addr),
      .o_rd_data (ram_rd_data),
      .i_wr_en   (writes_file & phase_end),
      .i_wr_addr (wr_addr),
      .i_wr_data (result_r)
   );

   // ****************************************
   // Phase sequencer
   // ****************************************
   assign step_q    = run_r | (q_r != 2'h0);
   assign phase_end = (q_r == `IWD_Q_LAST);

   // Four phases make one instruction cycle; a stop waits for phase one.
   always @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         q_r             <= 2'h0;
         o_cycle_start_r <= 1'b0;
      end else begin
         if (step_q) begin
            q_r <= q_r + 2'h1;
         end
         o_cycle_start_r <= run_r & phase_end;
      end
   end

   // Operand capture, processing and the visible read strobe.
   always @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         opnd_r       <= 8'h00;
         result_r     <= 8'h00;
         o_rmw_rd_r   <= 1'b0;
         o_rmw_addr_r <= {FA_W{1'b0}};
      end else begin
         o_rmw_rd_r <= need_read & (q_r == 2'h0) & step_q;
         if (need_read & (q_r == 2'h0) & step_q) begin
            o_rmw_addr_r <= file_addr;
         end
         if (q_r == 2'h1) begin
            opnd_r <= ram_rd_data;
         end
         if (q_r == 2'h2) begin
            result_r <= result_nxt;
         end
      end
   end

   // Fetch: at the end of each cycle take the next word or flush.
   always @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_pm_addr_r <= `IWD_PC_RST;
         ir_r        <= `IWD_NOP_WORD;
         w2_r        <= `IWD_NOP_WORD;
         second_r    <= 1'b0;
         flush_r     <= 1'b1;
      end else if (phase_end) begin
         if (jump_now) begin
            o_pm_addr_r <= is_branch_if_carry_set ? br_target : goto_target;
            flush_r     <= 1'b1;
            second_r    <= 1'b0;
         end else if (~nop_cyc & is_dword & ~second_r) begin
            w2_r        <= i_pm_word;
            second_r    <= 1'b1;
            o_pm_addr_r <= o_pm_addr_r + `IWD_PC_STEP;
         end else begin
            ir_r        <= i_pm_word;
            flush_r     <= 1'b0;
            second_r    <= 1'b0;
            o_pm_addr_r <= o_pm_addr_r + `IWD_PC_STEP;
         end
      end
   end

   // ****************************************
   // Software registers
   // ****************************************
   assign sw_wr_acc  = i_reg_wr & (i_reg_addr == `IWD_REG_ACC);
   assign sw_wr_stat = i_reg_wr & (i_reg_addr == `IWD_REG_STAT);

   // Control and bank selector; only software writes these.
   always @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         run_r           <= 1'b0;
         bank_selector_r <= `IWD_BANK_RST;
      end else if (i_reg_wr) begin
         if (i_reg_addr == `IWD_REG_CTRL) begin
            run_r <= i_reg_wdata[0];
         end
         if (i_reg_addr == `IWD_REG_BANK) begin
            bank_selector_r <= i_reg_wdata[3:0];
         end
      end
   end

   // Accumulator and flags; the instruction's own update wins a tie.
   always @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         working_accumulator_r <= `IWD_ACC_RST;
         flag_n_r              <= 1'b0;
         flag_z_r              <= 1'b0;
         flag_c_r              <= 1'b0;
      end else begin
         if (writes_acc & phase_end) begin
            working_accumulator_r <= result_r;
         end else if (sw_wr_acc) begin
            working_accumulator_r <= i_reg_wdata;
         end
         if (exec_now & is_and & phase_end) begin
            flag_n_r <= result_r[7];
            flag_z_r <= (result_r == 8'h00);
         end else if (sw_wr_stat) begin
            flag_n_r <= i_reg_wdata[`IWD_ST_N];
            flag_z_r <= i_reg_wdata[`IWD_ST_Z];
         end
         if (sw_wr_stat) begin
            flag_c_r <= i_reg_wdata[`IWD_ST_C];
         end
      end
   end

   // Read data stand in the cycle after the read strobe only.
   always @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_reg_rdata_r <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `IWD_REG_CTRL: o_reg_rdata_r <= {7'h00, run_r};
            `IWD_REG_BANK: o_reg_rdata_r <= {4'h0, bank_selector_r};
            `IWD_REG_ACC:  o_reg_rdata_r <= working_accumulator_r;
            `IWD_REG_STAT: o_reg_rdata_r <= {3'h0, flag_n_r, 1'b0, flag_z_r,
                                             1'b0, flag_c_r};
            `IWD_REG_PCL:  o_reg_rdata_r <= o_pm_addr_r[7:0];
            `IWD_REG_PCM:  o_reg_rdata_r <= o_pm_addr_r[15:8];
            `IWD_REG_PCH:  o_reg_rdata_r <= {3'h0, o_pm_addr_r[20:16]};
            `IWD_REG_IRL:  o_reg_rdata_r <= ir_r[7:0];
            `IWD_REG_IRH:  o_reg_rdata_r <= ir_r[15:8];
            default:       o_reg_rdata_r <= 8'h00;
         endcase
      end else begin
         o_reg_rdata_r <= 8'h00;
      end
   end

endmodule

// file: dv/iwd_decoder_chk.sv
/*
 Port checker for the instruction word decoder: cycle length, file
 read pulses, fetch addresses and register read data.
 Assumes it is bound to every iwd_decoder and sees only its ports.
*/
`timescale 1ns/100ps
`include "iwd_consts.vh"

module iwd_decoder_chk #(
   parameter FA_W = `IWD_FA_W
) (
   input wire                 i_clock,
   input wire                 i_nrst,
   input wire [15:0]          i_pm_word,
   input wire [`IWD_PC_W-1:0] o_pm_addr_r,
   input wire                 o_rmw_rd_r,
   input wire [FA_W-1:0]      o_rmw_addr_r,
   input wire                 o_cycle_start_r,
   input wire [3:0]           i_reg_addr,
   input wire [7:0]           i_reg_wdata,
   input wire                 i_reg_wr,
   input wire                 i_reg_rd,
   input wire [7:0]           o_reg_rdata_r
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   // The program counter holds for a whole four-clock cycle.
   a_cycle_len: assert property ($changed(o_pm_addr_r) |=> $stable(o_pm_addr_r)[*3])
      else $error("fetch address moved inside a cycle");
   a_start_gap: assert property (o_cycle_start_r |=> !o_cycle_start_r[*3])
      else $error("cycle start closer than four clocks");
   a_rmw_once: assert property (o_rmw_rd_r |=> !o_rmw_rd_r[*3])
      else $error("more than one file read in a cycle");
   a_rmw_hold: assert property (!o_rmw_rd_r |-> $stable(o_rmw_addr_r))
      else $error("file address moved without a read");
   a_rmw_then_pc: assert property (o_rmw_rd_r |-> ##[1:4] $changed(o_pm_addr_r))
      else $error("file read not followed by cycle end");
   a_pc_even: assert property (o_pm_addr_r[0] == 1'b0)
      else $error("odd fetch address");
   a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata_r == 8'h00)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property ($past(i_reg_rd) && ($past(i_reg_addr) > 4'h8)
      |-> o_reg_rdata_r == 8'h00)
      else $error("unmapped read not zero");

   // Main scenarios reached.
   cover property (o_rmw_rd_r);
   cover property (o_cycle_start_r ##4 o_cycle_start_r);
   cover property ($past(i_reg_rd) && o_reg_rdata_r != 8'h00);
endmodule

bind iwd_decoder iwd_decoder_chk #(.FA_W(FA_W)) u_chk (
   .i_clock(i_clock), .i_nrst(i_nrst), .i_pm_word(i_pm_word),
   .o_pm_addr_r(o_pm_addr_r), .o_rmw_rd_r(o_rmw_rd_r), .o_rmw_addr_r(o_rmw_addr_r),
   .o_cycle_start_r(o_cycle_start_r), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .o_reg_rdata_r(o_reg_rdata_r));

// file: dv/iwd_pm_model.sv
/*
 Program memory model: 256 words of 16 bits at byte addresses.
 Assumes the bench fills mem; in slow mode the word is garbage for
 the first clocks after each address change.
*/
`timescale 1ns/100ps

module iwd_pm_model (
   input  wire logic        i_clock,
   input  wire logic        i_slow,
   input  wire logic [20:0] i_addr,
   output logic      [15:0] o_word
);
   logic [15:0] mem [0:255];
   logic [20:0] addr_d = 21'h0;
   logic [1:0]  age = 2'h0;
   logic [15:0] word;

   // Counts how long the address has been steady.
   always @(posedge i_clock) begin
      addr_d <= i_addr;
      if (i_addr != addr_d)
         age <= 2'h0;
      else if (age != 2'h3)
         age <= age + 2'h1;
   end

   // A slow answer settles late but still within the cycle.
   assign word = mem[i_addr[8:1]];
   assign o_word = (i_slow && (i_addr != addr_d || age < 2'h2)) ? ~word : word;
endmodule

// file: dv/instruction_word_decoder_test.sv
/*
 Self-checking bench for the instruction word decoder.
 Assumes the program memory model and the bound port checker.
*/
`timescale 1ns/100ps
`include "iwd_consts.vh"

module instruction_word_decoder_test;
   logic        i_clock;
   logic        i_nrst;
   logic        i_reg_wr;
   logic        i_reg_rd;
   logic        slow;
   logic        rd_d;
   logic [3:0]  i_reg_addr;
   logic [7:0]  i_reg_wdata;
   logic [7:0]  acc;
   logic [7:0]  res;
   logic [2:0]  b;
   logic [2:0]  b2;
   logic [20:0] pc_d;
   logic [20:0] fq[$];
   logic [20:0] rq[$];
   logic [20:0] dq[$];
   wire  [15:0] i_pm_word;
   wire  [20:0] o_pm_addr_r;
   wire  [11:0] o_rmw_addr_r;
   wire  [7:0]  o_reg_rdata_r;
   wire         o_rmw_rd_r;
   wire         o_cycle_start_r;
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          c;

   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   iwd_decoder #(.FA_W(12)) uut (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_pm_word(i_pm_word),
      .o_pm_addr_r(o_pm_addr_r), .o_rmw_rd_r(o_rmw_rd_r), .o_rmw_addr_r(o_rmw_addr_r),
      .o_cycle_start_r(o_cycle_start_r), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata_r(o_reg_rdata_r));

   iwd_pm_model pm (.i_clock(i_clock), .i_slow(slow), .i_addr(o_pm_addr_r),
      .o_word(i_pm_word));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
      @(posedge i_clock);
   endtask

   // The expected data is noted; the monitor compares it.
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      dq.push_back({13'h0, e});
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clock);
      i_reg_rd <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic rst();
      i_nrst <= 1'b0;
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      repeat (4) @(posedge i_clock);
   endtask

   // Takes the oldest note for each fetch, file read and read answer.
   always @(posedge i_clock) begin
      pc_d <= o_pm_addr_r;
      rd_d <= i_reg_rd;
      if (rd_d)
         chk({13'h0, o_reg_rdata_r}, dq.pop_front());
      if (o_pm_addr_r !== pc_d && fq.size() > 0)
         chk(o_pm_addr_r, fq.pop_front());
      if (o_rmw_rd_r === 1'b1)
         chk({9'h0, o_rmw_addr_r}, rq.size() ? rq.pop_front() : '1);
      // A cycle start marks the clock in which a new fetch address appears.
      if (o_cycle_start_r === 1'b1)
         chk(21'(o_pm_addr_r !== pc_d), 21'h1);
      cycles++;
      if (cycles > 5000) begin
         mismatches++;
         end_of_test();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      i_nrst = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_reg_addr = 4'h0;
      i_reg_wdata = 8'h00;
      slow = 1'b0;
      c = $urandom(63020);
      rst();
      rd(`IWD_REG_CTRL, 8'h00);
      rd(`IWD_REG_BANK, 8'h00);
      rd(`IWD_REG_ACC, `IWD_ACC_RST);
      rd(`IWD_REG_PCL, 8'h00);
      rd(`IWD_REG_PCH, 8'h00);
      for (c = 0; c < 2; c++) begin
         if (c == 1)
            rst();
         b = 3'($urandom);
         b2 = b + 3'h1;
         acc = 8'($urandom);
         acc = c ? (acc | (8'h01 << b2)) : (acc & ~((8'h01 << b) | (8'h01 << b2)));
         res = acc & ((8'h01 << b) | (8'h01 << b2));
         // Clear every bit, set one and AND into the file, set another and AND into the accumulator.
         for (int k = 0; k < 256; k++)
            pm.mem[k] = (k < 8) ? {4'h9, k[2:0], 9'h110} : 16'h0000;
         pm.mem[8] = {4'h8, b, 9'h110};
         pm.mem[9] = 16'h1710;
         pm.mem[10] = {4'h8, b2, 9'h110};
         pm.mem[11] = 16'h1510;
         pm.mem[12] = {4'h9, b, 9'h085};
         pm.mem[13] = {4'hf, 12'($urandom)};
         pm.mem[14] = 16'hef20;
         pm.mem[15] = 16'hf000;
         pm.mem[16] = 16'h8112;
         pm.mem[32] = {7'h76, c[0], 8'h30};
         pm.mem[33] = 16'hf000;
         pm.mem[34] = 16'h8112;
         pm.mem[48] = 16'he208;
         pm.mem[49] = 16'h8011;
         pm.mem[50] = 16'hef39;
         pm.mem[51] = 16'hf000;
         pm.mem[52] = 16'h8112;
         pm.mem[57] = 16'he2ff;
         pm.mem[58] = 16'hc110;
         pm.mem[59] = 16'hf112;
         for (int k = 1; k <= 16; k++)
            fq.push_back(21'(2 * k));
         fq = {fq, 21'h40, 21'h42, 21'h44, 21'h60, 21'h62};
         if (c)
            fq = {fq, 21'h72, 21'h74, 21'h72, 21'h74};
         else
            fq = {fq, 21'h64, 21'h66, 21'h68, 21'h72, 21'h74, 21'h76, 21'h78, 21'h7a};
         for (int k = 0; k < 12; k++)
            rq.push_back(21'h110);
         rq.push_back(21'hf85);
         if (!c)
            rq = {rq, 21'h011, 21'h110};
         slow <= c[0];
         wr(`IWD_REG_BANK, 8'h01);
         wr(`IWD_REG_ACC, acc);
         wr(`IWD_REG_STAT, {7'h00, c[0]});
         wr(`IWD_REG_CTRL, 8'h01);
         while (fq.size() > 0)
            @(posedge i_clock);
         wr(`IWD_REG_CTRL, 8'h00);
         repeat (8) @(posedge i_clock);
         rd(`IWD_REG_ACC, res);
         rd(`IWD_REG_STAT, {3'h0, res[7], 1'b0, res == 8'h00, 1'b0, c[0]});
         rd(`IWD_REG_BANK, 8'h01);
         rd(4'hc, 8'h00);
         chk(21'(rq.size()), 21'h0);
      end
      end_of_test();
   end
endmodule
